// ===== hw/gpe_port.sv
// gpe_port: five-pin gpio port with pwm, debounced sampling and edge flags
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module gpe_port
  import gpe_pkg::*;
#(
  parameter int PWM_STEP_CYCLES = gpe_pkg::PWM_STEP_CYC,
  parameter int SAMPLE_CYCLES   = gpe_pkg::SAMPLE_CYC
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [gpe_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  input  wire logic [gpe_pkg::ADDR_W-1:0]  araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  input  wire logic [gpe_pkg::NPINS-1:0]   pin_i,
  output logic [gpe_pkg::NPINS-1:0]        pin_o,
  output logic [gpe_pkg::NPINS-1:0]        pin_oe,
  output logic [gpe_pkg::NPINS-1:0]        pull_up_en,
  output logic [gpe_pkg::NPINS-1:0]        pull_dn_en,
  output logic [gpe_pkg::NPINS-1:0]        slow_en,
  input  wire logic [gpe_pkg::NPINS-1:0]   dflt_lvl,
  output logic [gpe_pkg::NPINS-1:0]        pin_level
);
  import gpe_pkg::*;

  // {oe, out, pull up, pull down, slow} for a logical level
  function automatic logic [4:0] drive(input logic [2:0] mode, input logic l);
    logic [4:0] d;
    d = 5'h00;
    unique case (gpe_drive_t'(mode))
      DRV_UP_PD:     d = l ? 5'h18 : 5'h02;
      DRV_PUSH:      d = {1'b1, l, 3'h0};
      DRV_HIZ:       d = 5'h00;
      DRV_PU_DN:     d = l ? 5'h04 : 5'h10;
      DRV_SLOW_UP:   d = l ? 5'h19 : 5'h00;
      DRV_SLOW_PUSH: d = {1'b1, l, 3'h1};
      DRV_RSVD:      d = 5'h00;  // reserved: parked hi-z
      DRV_SLOW_DN:   d = l ? 5'h00 : 5'h11;
    endcase
    return d;
  endfunction

  // {hit, index} for a per-pin status address
  function automatic logic [3:0] stat_sel(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = ((a & STAT_BASE_MASK) == REG_STAT_BASE) && (a[1:0] == 2'h0)
          && (a[4:2] < 3'(NPINS));
    return {hit, a[4:2]};
  endfunction

  logic [ADDR_W-1:0]       wr_addr;
  logic [31:0]             wr_data;
  logic [3:0]              wr_strb;
  logic                    aw_full;
  logic                    w_full;
  logic                    wr_en;
  logic                    rd_en;
  logic                    next_rvalid;
  logic [3:0]              rd_sel;
  logic [3:0]              wr_sel;
  logic [7:0]              cmd_type;
  logic [1:0]              cmd_len;
  logic [23:0]             cmd_data;
  logic                    cmd_go;
  logic [7:0]              ack_type;
  logic                    ack_valid;
  logic                    ack_reject;
  logic                    cmd_ok;
  logic                    ack_clr;
  logic [NPINS-1:0][7:0]   pin_duty;
  logic [NPINS-1:0][7:0]   pin_cfg;
  logic [NPINS-1:0][7:0]   boot_duty;
  logic [NPINS-1:0][7:0]   boot_cfg;
  logic                    boot_save;
  logic                    boot_restore;
  logic [31:0]             step_cnt;
  logic                    step_tick;
  logic [6:0]              pwm_cnt;
  logic [NPINS-1:0]        user_lvl;
  logic [NPINS-1:0]        drv_lvl;
  logic [31:0]             smp_cnt;
  logic                    smp_tick;
  logic [NPINS-1:0]        in_meta;
  logic [NPINS-1:0]        in_sync;
  logic [NPINS-1:0]        smp_prev;
  logic [NPINS-1:0]        deb_lvl;
  logic [NPINS-1:0]        rise_set;
  logic [NPINS-1:0]        fall_set;
  logic [NPINS-1:0]        flag_clr;
  logic [NPINS-1:0]        rise_flag;
  logic [NPINS-1:0]        fall_flag;

  // write channel: address and data taken in either order
  assign wr_en = aw_full & w_full & ~bvalid;
  assign wr_sel = stat_sel(wr_addr);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      awready <= 1'b0;
      wr_addr <= '0;
    end else if (awvalid && awready) begin
      aw_full <= 1'b1;
      awready <= 1'b0;
      wr_addr <= awaddr;
    end else begin
      aw_full <= aw_full & ~wr_en;
      awready <= ~(aw_full & ~wr_en);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full  <= 1'b0;
      wready  <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (wvalid && wready) begin
      w_full  <= 1'b1;
      wready  <= 1'b0;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end else begin
      w_full <= w_full & ~wr_en;
      wready <= ~(w_full & ~wr_en);
    end
  end

  // write response; unmapped or read-only targets answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp  <= (wr_addr == REG_CMD || wr_addr == REG_CMD_DATA ||
                 wr_addr == REG_BOOT) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // command registers; writing the type byte issues the packet
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_type <= 8'h00;
      cmd_len  <= 2'h0;
      cmd_data <= 24'h000000;
      cmd_go   <= 1'b0;
    end else begin
      cmd_go <= wr_en && wr_addr == REG_CMD && wr_strb[0];
      if (wr_en && wr_addr == REG_CMD) begin
        if (wr_strb[0])
          cmd_type <= wr_data[7:0];
        if (wr_strb[1])
          cmd_len <= wr_data[CMD_LEN_LSB +: 2];
      end
      if (wr_en && wr_addr == REG_CMD_DATA) begin
        for (int b = 0; b < 3; b++) begin
          if (wr_strb[b])
            cmd_data[8*b +: 8] <= wr_data[8*b +: 8];
        end
      end
    end
  end

  // accept only a config packet of two or three bytes naming pin 0..4
  assign cmd_ok = cmd_type == CMD_CFG_TYPE &&
                  (cmd_len == CMD_LEN_VALUE || cmd_len == CMD_LEN_FULL) &&
                  cmd_data[7:0] < 8'(NPINS);
  assign boot_save    = wr_en && wr_addr == REG_BOOT && wr_strb[0] &&
                        wr_data[BOOT_SAVE_BIT];
  assign boot_restore = wr_en && wr_addr == REG_BOOT && wr_strb[0] &&
                        wr_data[BOOT_RESTORE_BIT];

  // pin settings: factory values after reset, reloadable from boot copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_duty <= FACTORY_DUTY;
      pin_cfg  <= FACTORY_CFG;
    end else if (cmd_go && cmd_ok) begin
      pin_duty[cmd_data[2:0]] <= cmd_data[15:8];
      if (cmd_len == CMD_LEN_FULL)
        pin_cfg[cmd_data[2:0]] <= cmd_data[23:16] & CFG_MASK;
    end else if (boot_restore) begin
      pin_duty <= boot_duty;
      pin_cfg  <= boot_cfg;
    end
  end

  // boot copy; nonvolatile storage itself lives outside this block
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_duty <= FACTORY_DUTY;
      boot_cfg  <= FACTORY_CFG;
    end else if (boot_save) begin
      boot_duty <= pin_duty;
      boot_cfg  <= pin_cfg;
    end
  end

  // acknowledge word; a new answer wins over the clearing read
  assign ack_clr = rd_en && araddr == REG_ACK;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_type   <= 8'h00;
      ack_valid  <= 1'b0;
      ack_reject <= 1'b0;
    end else if (cmd_go) begin
      ack_type   <= cmd_ok ? (cmd_type | ACK_FLAG) : 8'h00;
      ack_valid  <= cmd_ok;
      ack_reject <= ~cmd_ok;
    end else if (ack_clr) begin
      ack_valid  <= 1'b0;
      ack_reject <= 1'b0;
    end
  end

  // pwm step timer and 100-step period counter
  assign step_tick = step_cnt == 32'(PWM_STEP_CYCLES - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_cnt <= 32'h0;
      pwm_cnt  <= 7'h00;
    end else begin
      step_cnt <= step_tick ? 32'h0 : step_cnt + 32'h1;
      if (step_tick)
        pwm_cnt <= (pwm_cnt == 7'(PWM_STEPS - 1)) ? 7'h00 :
                   pwm_cnt + 7'h01;
    end
  end

  // requested level: 0 low, 100 high, between is the duty percentage
  always_comb begin
    for (int p = 0; p < NPINS; p++) begin
      user_lvl[p] = {1'b0, pwm_cnt} < pin_duty[p];
      drv_lvl[p]  = pin_cfg[p][CFG_FN_BIT] ? user_lvl[p]
                                            : dflt_lvl[p];
    end
  end

  // pad controls through the drive mode, registered so pads never glitch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_oe     <= '0;
      pin_o      <= '0;
      pull_up_en <= '0;
      pull_dn_en <= '0;
      slow_en    <= '0;
    end else begin
      for (int p = 0; p < NPINS; p++) begin
        {pin_oe[p], pin_o[p], pull_up_en[p], pull_dn_en[p], slow_en[p]} <=
          drive(pin_cfg[p][2:0], drv_lvl[p]);
      end
    end
  end

  // pad inputs pass two flops before anything reads them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_meta <= '0;
      in_sync <= '0;
    end else begin
      in_meta <= pin_i;
      in_sync <= in_meta;
    end
  end

  // 32 Hz sample timer runs regardless of pin configuration
  assign smp_tick = smp_cnt == 32'(SAMPLE_CYCLES - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn)
      smp_cnt <= 32'h0;
    else
      smp_cnt <= smp_tick ? 32'h0 : smp_cnt + 32'h1;
  end

  // level moves only after two agreeing samples; a bounce costs one period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smp_prev <= '0;
      deb_lvl  <= '0;
    end else if (smp_tick) begin
      smp_prev <= in_sync;
      for (int p = 0; p < NPINS; p++) begin
        if (in_sync[p] == smp_prev[p])
          deb_lvl[p] <= in_sync[p];
      end
    end
  end

  always_comb begin
    for (int p = 0; p < NPINS; p++) begin
      rise_set[p] = smp_tick && in_sync[p] == smp_prev[p] &&
                    in_sync[p] && !deb_lvl[p];
      fall_set[p] = smp_tick && in_sync[p] == smp_prev[p] &&
                    !in_sync[p] && deb_lvl[p];
      flag_clr[p] = rd_en && rd_sel[3] && rd_sel[2:0] == 3'(p);
    end
  end

  // sticky edge flags; an edge in the clearing cycle is kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rise_flag <= '0;
      fall_flag <= '0;
      pin_level <= '0;
    end else begin
      rise_flag <= rise_set | (rise_flag & ~flag_clr);
      fall_flag <= fall_set | (fall_flag & ~flag_clr);
      pin_level <= deb_lvl;
    end
  end

  // read channel: one read at a time, data latched at the address edge
  assign rd_en       = arvalid & arready;
  assign next_rvalid = rd_en | (rvalid & ~rready);
  assign rd_sel      = stat_sel(araddr);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= ~next_rvalid;
      rvalid  <= next_rvalid;
      if (rd_en) begin
        rresp <= RESP_OKAY;
        rdata <= 32'h0;
        if (rd_sel[3]) begin
          rdata[STAT_LVL_BIT]  <= deb_lvl[rd_sel[2:0]];
          rdata[STAT_FALL_BIT] <= fall_flag[rd_sel[2:0]];
          rdata[STAT_RISE_BIT] <= rise_flag[rd_sel[2:0]];
          rdata[STAT_DUTY_LSB +: 8] <= pin_duty[rd_sel[2:0]];
          rdata[STAT_CFG_LSB +: 8]  <= pin_cfg[rd_sel[2:0]];
        end else if (araddr == REG_CMD)
          rdata[9:0] <= {cmd_len, cmd_type};
        else if (araddr == REG_CMD_DATA)
          rdata[23:0] <= cmd_data;
        else if (araddr == REG_ACK)
          rdata[9:0] <= {ack_reject, ack_valid, ack_type};
        else if (araddr == REG_LEVELS)
          rdata[NPINS-1:0] <= deb_lvl;
        else if (araddr != REG_BOOT)
          rresp <= RESP_SLVERR;
      end
    end
  end

  AST_BAD_INDEX: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_go && cmd_data[7:0] >= 8'(NPINS) |=> $stable(pin_cfg) && !ack_valid)
    else $error("out-of-range pin index changed state or was acknowledged");

  AST_ACK_TYPE: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_go && cmd_ok |=> ack_valid && ack_type == 8'h62)
    else $error("accepted command not acknowledged with type 0x62");

  AST_VALUE_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_go && cmd_ok && cmd_len == CMD_LEN_VALUE
    |=> $stable(pin_cfg) &&
        pin_duty[$past(cmd_data[2:0])] == $past(cmd_data[15:8]))
    else $error("two-byte command touched config or missed value");

  AST_DUTY_ENDS: assert property (@(posedge aclk) disable iff (!aresetn)
    (pin_duty[0] == 8'h00 |-> !user_lvl[0]) and
    (pin_duty[0] == DUTY_FULL |-> user_lvl[0]))
    else $error("duty 0 or 100 not steady");

  AST_PWM_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
    step_tick && pwm_cnt == 7'h63 |=> pwm_cnt == 7'h00 ##1 pwm_cnt == 7'h00)
    else $error("pwm period counter did not wrap at 100 steps");

  AST_HIZ_MODE: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_cfg[0][2:0] == 3'b010
    |=> !pin_oe[0] && !pull_up_en[0] && !pull_dn_en[0])
    else $error("hi-z drive mode still drives the pin");

  AST_PULLUP_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_cfg[0][2:0] == 3'b011 && drv_lvl[0] |=> pull_up_en[0] && !pin_oe[0])
    else $error("pull-up mode high did not release to pull-up");

  AST_DEB_TICK: assert property (@(posedge aclk) disable iff (!aresetn)
    !$stable(deb_lvl) |-> $past(smp_tick) &&
    ((deb_lvl ^ $past(deb_lvl)) & ($past(in_sync) ^ $past(smp_prev))) == '0)
    else $error("level changed without two agreeing samples");

  AST_RISE_SEEN: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(deb_lvl[0]) |-> rise_flag[0] && !$rose(fall_flag[0]))
    else $error("rising level not recorded as rising edge");

  AST_READ_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn)
    flag_clr[0] && !rise_set[0] && !fall_set[0]
    |=> !rise_flag[0] && !fall_flag[0])
    else $error("status read did not clear edge flags");
endmodule

// ===== hw/gpe_pkg.sv
// package: constants and types of the five-pin gpio, pwm and edge port
package gpe_pkg;
  localparam int          NPINS            = 5;
  localparam int          ADDR_W           = 8;
  // register byte addresses
  localparam logic [7:0]  REG_CMD          = 8'h00;
  localparam logic [7:0]  REG_CMD_DATA     = 8'h04;
  localparam logic [7:0]  REG_ACK          = 8'h08;
  localparam logic [7:0]  REG_LEVELS       = 8'h0C;
  localparam logic [7:0]  REG_BOOT         = 8'h10;
  localparam logic [7:0]  REG_STAT_BASE    = 8'h20;
  localparam logic [7:0]  STAT_BASE_MASK   = 8'hE0;
  // command packet codes
  localparam logic [7:0]  CMD_CFG_TYPE     = 8'h22;
  localparam logic [7:0]  ACK_FLAG         = 8'h40;
  localparam logic [1:0]  CMD_LEN_VALUE    = 2'h2;
  localparam logic [1:0]  CMD_LEN_FULL     = 2'h3;
  // field positions
  localparam int          CMD_LEN_LSB      = 8;
  localparam int          ACK_VALID_BIT    = 8;
  localparam int          ACK_REJECT_BIT   = 9;
  localparam int          BOOT_SAVE_BIT    = 0;
  localparam int          BOOT_RESTORE_BIT = 1;
  localparam int          STAT_LVL_BIT     = 0;
  localparam int          STAT_FALL_BIT    = 1;
  localparam int          STAT_RISE_BIT    = 2;
  localparam int          STAT_DUTY_LSB    = 8;
  localparam int          STAT_CFG_LSB     = 16;
  localparam int          CFG_FN_BIT       = 3;
  localparam logic [7:0]  CFG_MASK         = 8'h0F;
  localparam logic [7:0]  DUTY_FULL        = 8'h64;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
  // timing
  localparam int          CLK_HZ           = 100_000_000;
  localparam int          PWM_RATE_HZ      = 100;
  localparam int          PWM_STEPS        = 100;
  localparam int          SAMPLE_RATE_HZ   = 32;
  localparam int          PWM_STEP_CYC     = CLK_HZ / (PWM_RATE_HZ * PWM_STEPS);
  localparam int          SAMPLE_CYC       = CLK_HZ / SAMPLE_RATE_HZ;
  // factory values: atx sense pull-up, atx and one-wire pins hi-z
  localparam logic [NPINS-1:0][7:0] FACTORY_DUTY = '0;
  localparam logic [NPINS-1:0][7:0] FACTORY_CFG  =
    {8'h02, 8'h02, 8'h02, 8'h03, 8'h02};
  typedef enum logic [2:0] {
    DRV_UP_PD     = 3'b000,
    DRV_PUSH      = 3'b001,
    DRV_HIZ       = 3'b010,
    DRV_PU_DN     = 3'b011,
    DRV_SLOW_UP   = 3'b100,
    DRV_SLOW_PUSH = 3'b101,
    DRV_RSVD      = 3'b110,
    DRV_SLOW_DN   = 3'b111
  } gpe_drive_t;
endpackage

// ===== tb/gpe_pad_model.sv
// pad model: drivers, pull resistors, ground switch, floating pads
`timescale 1ns/1ps
module gpe_pad_model (
  input  wire logic       aclk,
  input  wire logic [4:0] pin_o,
  input  wire logic [4:0] pin_oe,
  input  wire logic [4:0] pull_up_en,
  input  wire logic [4:0] pull_dn_en,
  input  wire logic [4:0] sw_closed,
  output logic      [4:0] pad
);
  logic [4:0] flt = 5'h0A;
  // undriven pads wander so a stale level never reads as valid
  always @(posedge aclk) flt <= ~flt;
  // strong drive wins, then switch to ground, then the ~5k pulls
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (pin_oe[i]) pad[i] = pin_o[i];
      else if (sw_closed[i]) pad[i] = 1'b0;
      else if (pull_up_en[i]) pad[i] = 1'b1;
      else if (pull_dn_en[i]) pad[i] = 1'b0;
      else pad[i] = flt[i];
    end
  end
endmodule

// ===== tb/gpe_port_tb.sv
// testbench of the gpio, pwm and edge port
`timescale 1ns/1ps
module gpe_port_tb;
  import gpe_pkg::*;
  typedef struct packed {
    logic [7:0]  ty;
    logic [1:0]  ln;
    logic [23:0] dt;
    logic [31:0] ack;
    logic [15:0] stat;
  } gpe_row_t;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd, cnt;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic [4:0]  pin_i, pin_o, pin_oe, pull_up_en, pull_dn_en, slow_en;
  logic [4:0]  dflt_lvl, pin_level, sw_closed;
  int          err_count, total_checks;
  // pin 0 targets except two rows naming pins 5 and 255; stat is the expected duty/config of pin 0 afterwards
  gpe_row_t rows [8] = '{
    '{8'h22, 2'h3, 24'h090000, 32'h162, 16'h0900},
    '{8'h22, 2'h2, 24'h006400, 32'h162, 16'h0964},
    '{8'h22, 2'h3, 24'h093205, 32'h200, 16'h0964},
    '{8'h22, 2'h3, 24'h0932FF, 32'h200, 16'h0964},
    '{8'h21, 2'h3, 24'h093200, 32'h200, 16'h0964},
    '{8'h22, 2'h1, 24'h093200, 32'h200, 16'h0964},
    '{8'h22, 2'h3, 24'h013200, 32'h162, 16'h0132},
    '{8'h22, 2'h2, 24'h0F0000, 32'h162, 16'h0100}};
  logic [7:0] duty [3] = '{8'h01, 8'h32, 8'h63};
  gpe_port #(.PWM_STEP_CYCLES(4), .SAMPLE_CYCLES(16)) dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
    .pull_dn_en(pull_dn_en), .slow_en(slow_en), .dflt_lvl(dflt_lvl),
    .pin_level(pin_level));
  gpe_pad_model u_pad (
    .aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
    .pull_dn_en(pull_dn_en), .sw_closed(sw_closed), .pad(pin_i));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_word(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pins(input string nm, input logic [4:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic tmo(input string nm);
    err_count++;
    $display("MISMATCH %s expected answer seen timeout", nm);
    print_verdict;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge aclk);
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    rs = bresp;
    bready <= 1'b0;
    if (n == 50) tmo("bvalid");
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (n == 50) tmo("rvalid");
  endtask
  // command packet, then poll the acknowledge word until it shows a result
  task automatic cmd(input logic [7:0] ty, input logic [1:0] ln,
                     input logic [23:0] dt);
    int n;
    axi_wr(REG_CMD_DATA, {8'h00, dt});
    axi_wr(REG_CMD, {22'h0, ln, ty});
    for (n = 0; n < 20; n++) begin
      axi_rd(REG_ACK);
      if (rd[9:8] != 2'b00) break;
    end
    if (n == 20) tmo("ack");
  endtask
  // expected {oe, driven level, pull up, pull down, driven slow}
  function automatic logic [4:0] pads(input logic [2:0] m, input logic l);
    case (m)
      3'b000: pads = l ? 5'h18 : 5'h02;
      3'b001: pads = l ? 5'h18 : 5'h10;
      3'b011: pads = l ? 5'h04 : 5'h10;
      3'b100: pads = l ? 5'h19 : 5'h00;
      3'b101: pads = l ? 5'h19 : 5'h11;
      3'b111: pads = l ? 5'h00 : 5'h11;
      default: pads = 5'h00;
    endcase
  endfunction
  task automatic chk_drive(input int p, input logic [4:0] e);
    cyc(3);
    chk_pins("drive", e, {pin_oe[p], pin_oe[p] & pin_o[p], pull_up_en[p],
             pull_dn_en[p], pin_oe[p] & slow_en[p]});
  endtask
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    wstrb = 4'hF;
    dflt_lvl = 5'h1F;
    sw_closed = 5'h00;
    aresetn = 1'b0;
    err_count = 0;
    total_checks = 0;
    do_reset;
    for (int i = 0; i < 5; i++) begin
      axi_rd(REG_STAT_BASE + 8'(4 * i));
      chk_word("stat", (i == 1) ? 32'h300 : 32'h200, {16'h0, rd[23:8]});
    end
    chk_pins("oe", 5'h00, pin_oe);
    axi_rd(8'h40);
    chk_word("unmapped", {30'h0, RESP_SLVERR}, {rd[29:0], rs});
    axi_wr(REG_LEVELS, 32'h1F);
    chk_word("ro write", {30'h0, RESP_SLVERR}, {30'h0, rs});
    $display("reset and map test done");
    // pin 1 keeps its pull-up; a switch to ground pulls it low
    cyc(80);
    axi_rd(REG_STAT_BASE + 8'h04);
    @(posedge aclk);
    sw_closed <= 5'h02;
    cyc(80);
    chk_pins("level", 5'h00, pin_level & 5'h02);
    axi_rd(REG_STAT_BASE + 8'h04);
    chk_word("fall", 32'h2, rd & 32'h7);
    axi_rd(REG_STAT_BASE + 8'h04);
    chk_word("cleared", 32'h0, rd & 32'h7);
    @(posedge aclk);
    sw_closed <= 5'h00;
    cyc(80);
    axi_rd(REG_STAT_BASE + 8'h04);
    chk_word("rise", 32'h5, rd & 32'h7);
    // a closure shorter than one sample period must leave no trace
    @(posedge aclk);
    sw_closed <= 5'h02;
    repeat (8) @(posedge aclk);
    sw_closed <= 5'h00;
    cyc(80);
    axi_rd(REG_STAT_BASE + 8'h04);
    chk_word("bounce", 32'h1, rd & 32'h7);
    axi_rd(REG_LEVELS);
    chk_word("levels", 32'h2, rd & 32'h2);
    $display("edge test done");
    foreach (rows[i]) begin
      cmd(rows[i].ty, rows[i].ln, rows[i].dt);
      chk_word("ack", rows[i].ack, rd);
      axi_rd(REG_STAT_BASE);
      chk_word("stat0", {16'h0, rows[i].stat}, {16'h0, rd[23:8]});
    end
    axi_rd(REG_ACK);
    chk_word("ack clear", 32'h0, rd & 32'h300);
    $display("command table done");
    for (int m = 0; m < 8; m++) begin
      if (m == 6) continue;
      for (int l = 0; l < 2; l++) begin
        cmd(8'h22, 2'h3, {5'h1, 3'(m), (l == 1) ? DUTY_FULL : 8'h00, 8'h00});
        chk_drive(0, pads(3'(m), l[0]));
      end
    end
    $display("drive mode test done");
    // any 400-cycle window spans one full period of 100 steps of 4
    foreach (duty[k]) begin
      cmd(8'h22, 2'h3, {8'h09, duty[k], 8'h00});
      cyc(8);
      cnt = 0;
      repeat (400) begin
        @(negedge aclk);
        cnt = cnt + pin_o[0];
      end
      chk_word("pwm high", {22'h0, duty[k], 2'b00}, cnt);
    end
    $display("pwm test done");
    cmd(8'h22, 2'h3, 24'h010000);
    @(posedge aclk);
    dflt_lvl <= 5'h1E;
    chk_drive(0, pads(3'b001, 1'b0));
    @(posedge aclk);
    dflt_lvl <= 5'h1F;
    chk_drive(0, pads(3'b001, 1'b1));
    $display("default function test done");
    axi_wr(REG_BOOT, 32'h1);
    cmd(8'h22, 2'h3, 24'h0A6400);
    axi_wr(REG_BOOT, 32'h2);
    axi_rd(REG_STAT_BASE);
    chk_word("restore", 32'h100, {16'h0, rd[23:8]});
    axi_rd(REG_BOOT);
    chk_word("boot read", 32'h0, rd);
    do_reset;
    axi_rd(REG_STAT_BASE);
    chk_word("rereset", 32'h200, {16'h0, rd[23:8]});
    $display("boot and reset test done");
    print_verdict;
  end
endmodule
